// ---- verilog/dio_cfg.svh ----
`ifndef DIO_CFG_SVH
`define DIO_CFG_SVH
// Register byte offsets.
`define DIO_OFF_CTRL     12'h000
`define DIO_OFF_IN_FUNC  12'h004
`define DIO_OFF_OUT_FUNC 12'h008
`define DIO_OFF_STATUS   12'h00c
`define DIO_OFF_TERM     12'h010
`define DIO_OFF_COUNT    12'h014
`define DIO_OFF_ALARM    12'h018
// Field widths of one terminal's function code.
`define DIO_IN_FW        5
`define DIO_OUT_FW       4
// Reset and factory default values.
`define DIO_MODE_RST     2'h0
`define DIO_IN_FUNC_RST  25'h0b1a0e6
`define DIO_OUT_FUNC_RST 12'h431
// Input function codes.
`define DIO_FN_ORIGIN    5'h03
`define DIO_FN_FWD_LIM   5'h04
`define DIO_FN_BWD_LIM   5'h05
`define DIO_FN_ENABLE    5'h06
`define DIO_FN_RELEASE   5'h07
`define DIO_FN_ALM_CLR   5'h08
`define DIO_FN_RESTORE   5'h09
`define DIO_FN_STOP      5'h0a
`define DIO_FN_ESTOP     5'h0b
`define DIO_FN_POS_MOVE  5'h0c
`define DIO_FN_SPD_MOVE  5'h0d
`define DIO_FN_JOG_FWD   5'h0e
`define DIO_FN_JOG_BWD   5'h0f
`define DIO_FN_HOME      5'h10
`define DIO_FN_MULTI     5'h11
`define DIO_FN_SEG_BASE  5'h12
// Output function codes.
`define DIO_OF_ALARM     4'h1
`define DIO_OF_HOME_OK   4'h2
`define DIO_OF_RUNNING   4'h3
`define DIO_OF_POS_OK    4'h4
`define DIO_OF_MULTI     4'h5
`define DIO_OF_SEG_BASE  4'h6
`endif

// ---- verilog/dio_pkg.sv ----
package dio_pkg;
	typedef enum logic [1:0] {
		dio_mode_bus        = 2'h0,
		dio_mode_ext_dir    = 2'h1,
		dio_mode_pulse_dir  = 2'h2,
		dio_mode_dual_pulse = 2'h3
	} dio_mode_t;
	typedef enum logic [1:0] {
		dio_home_idle = 2'b00,
		dio_home_back = 2'b01,
		dio_home_fwd  = 2'b11,
		dio_home_done = 2'b10
	} dio_home_t;
	typedef struct packed {
		logic       energise;
		logic       decel_stop;
		logic       halt;
		logic       start_position;
		logic       start_speed;
		logic       jog_fwd;
		logic       jog_bwd;
		logic       home_back;
		logic       home_fwd;
		logic       multi_start;
		logic [4:0] segment_select;
		logic       fwd_limit;
		logic       bwd_limit;
		logic       restore_defaults;
		logic       ext_direction;
	} dio_cmd_t;
	typedef struct packed {
		logic       moving;
		logic       at_target;
		logic       multi_active;
		logic [2:0] segment_status;
	} dio_sts_t;
	typedef struct packed {
		logic nvm_error;
		logic comm_error;
		logic over_voltage;
		logic under_voltage;
	} dio_fault_t;
endpackage : dio_pkg

// ---- verilog/dio_terminals.sv ----
`timescale 1ns/1ps
`include "dio_cfg.svh"
module dio_terminals
	import dio_pkg::*;
(
	// Clock and reset.
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Terminal pins.
	input  wire logic        step_pulse_in,
	input  wire logic        step_direction_in,
	input  wire logic [4:0]  general_input,
	output logic      [2:0]  general_output,
	// Motion core.
	output dio_cmd_t         motion_cmd,
	input  wire dio_sts_t    motion_sts,
	input  wire dio_fault_t  fault_in
);
	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [6:0]  pin_meta_reg;
	logic [6:0]  pin_sync_reg;
	logic [6:0]  pin_last_reg;
	logic [6:0]  pin_rise;
	logic [4:0]  term_lvl;
	logic [4:0]  term_rise;

	// Only the second stage is read; the third stage exists for edge detection.
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			pin_meta_reg <= 7'h00;
			pin_sync_reg <= 7'h00;
			pin_last_reg <= 7'h00;
		end
		else
		begin
			pin_meta_reg <= {general_input, step_direction_in, step_pulse_in};
			pin_sync_reg <= pin_meta_reg;
			pin_last_reg <= pin_sync_reg;
		end
	end

	// Levels and rising edges of the synchronised pins.
	assign pin_rise  = pin_sync_reg & ~pin_last_reg;
	assign term_lvl  = pin_sync_reg[6:2];
	assign term_rise = pin_rise[6:2];

	// ------------------------------------------------------------
	// Function decode
	// ------------------------------------------------------------
	logic [24:0] in_func_reg;
	logic [11:0] out_func_reg;
	dio_mode_t   mode_reg;
	logic [31:0] lvl_hit  [5];
	logic [31:0] rise_hit [5];
	logic [31:0] fn_lvl;
	logic [31:0] fn_rise;
	logic [31:0] fn_mask;
	logic        ext_mode;

	// Each terminal turns its level into a one-hot function vector.
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++)
		begin : g_term
			assign lvl_hit[gi]  = term_lvl[gi]  ? (32'h1 << in_func_reg[gi*`DIO_IN_FW +: `DIO_IN_FW]) : 32'h0;
			assign rise_hit[gi] = term_rise[gi] ? (32'h1 << in_func_reg[gi*`DIO_IN_FW +: `DIO_IN_FW]) : 32'h0;
		end
	endgenerate

	// Under external pulse control only four functions stay live.
	assign ext_mode = (mode_reg != dio_mode_bus);
	always_comb
	begin
		fn_lvl  = 32'h0;
		fn_rise = 32'h0;
		fn_mask = 32'hffffffff;
		for (int i = 0; i < 5; i++)
		begin
			fn_lvl  = fn_lvl | lvl_hit[i];
			fn_rise = fn_rise | rise_hit[i];
		end
		if (ext_mode)
		begin
			fn_mask = 32'h0;
			fn_mask[`DIO_FN_ENABLE]  = 1'b1;
			fn_mask[`DIO_FN_RELEASE] = 1'b1;
			fn_mask[`DIO_FN_ALM_CLR] = 1'b1;
			fn_mask[`DIO_FN_RESTORE] = 1'b1;
		end
		fn_lvl  = fn_lvl & fn_mask;
		fn_rise = fn_rise & fn_mask;
	end

	// ------------------------------------------------------------
	// Motion and status logic
	// ------------------------------------------------------------
	logic        energise_reg,  energise_next;
	logic        nvm_alarm_reg, nvm_alarm_next;
	logic        comm_alarm_reg, comm_alarm_next;
	logic        pos_mode_reg,  pos_mode_next;
	dio_home_t   home_reg,      home_next;
	logic [31:0] count_reg,     count_next;
	dio_cmd_t    cmd_reg,       cmd_next;
	logic [2:0]  gout_reg,      gout_next;
	logic        alarm;
	logic        pos_ok;
	logic [15:0] out_src;
	logic        halt;

	assign alarm  = nvm_alarm_reg | comm_alarm_reg | fault_in.over_voltage | fault_in.under_voltage;
	assign pos_ok = pos_mode_reg & motion_sts.at_target & ~motion_sts.moving;
	assign halt   = fn_lvl[`DIO_FN_ESTOP];

	// Next values of motor state, alarms, homing, step count and outputs.
	always_comb
	begin
		energise_next   = energise_reg;
		pos_mode_next   = pos_mode_reg;
		home_next       = home_reg;
		count_next      = count_reg;
		cmd_next        = cmd_reg;
		gout_next       = 3'h0;
		out_src         = 16'h0;
		// Release is checked last so that it wins over a same-cycle enable.
		if (fn_rise[`DIO_FN_ENABLE])
			energise_next = 1'b1;
		if (fn_lvl[`DIO_FN_RELEASE])
			energise_next = 1'b0;
		// A new fault in the cycle of a clear is kept: the set wins.
		nvm_alarm_next  = fault_in.nvm_error  | (nvm_alarm_reg  & ~fn_lvl[`DIO_FN_ALM_CLR]);
		comm_alarm_next = fault_in.comm_error | (comm_alarm_reg & ~fn_lvl[`DIO_FN_ALM_CLR]);
		// Step counting; in dual-pulse mode the direction pin carries reverse pulses.
		unique case (mode_reg)
			dio_mode_pulse_dir:
			begin
				if (pin_rise[0])
					count_next = pin_sync_reg[1] ? count_reg - 32'h1 : count_reg + 32'h1;
			end
			dio_mode_dual_pulse:
			begin
				if (pin_rise[0] && !pin_rise[1])
					count_next = count_reg + 32'h1;
				else if (pin_rise[1] && !pin_rise[0])
					count_next = count_reg - 32'h1;
			end
			default:
			begin
				count_next = count_reg;
			end
		endcase
		// Homing search: backward first, turn at the backward limit, stop on origin.
		unique case (home_reg)
			dio_home_idle:
			begin
				if (fn_rise[`DIO_FN_HOME] && !halt)
					home_next = dio_home_back;
			end
			dio_home_back:
			begin
				if (halt || fn_rise[`DIO_FN_STOP])
					home_next = dio_home_idle;
				else if (fn_lvl[`DIO_FN_ORIGIN])
					home_next = dio_home_done;
				else if (fn_lvl[`DIO_FN_BWD_LIM])
					home_next = dio_home_fwd;
			end
			dio_home_fwd:
			begin
				if (halt || fn_rise[`DIO_FN_STOP] || fn_lvl[`DIO_FN_FWD_LIM])
					home_next = dio_home_idle;
				else if (fn_lvl[`DIO_FN_ORIGIN])
					home_next = dio_home_done;
			end
			dio_home_done:
			begin
				if (fn_rise[`DIO_FN_HOME] && !halt)
					home_next = dio_home_back;
				else if (fn_rise[`DIO_FN_POS_MOVE] || fn_rise[`DIO_FN_SPD_MOVE])
					home_next = dio_home_idle;
			end
		endcase
		// Commands to the motion core.
		cmd_next.energise         = energise_next;
		cmd_next.decel_stop       = fn_rise[`DIO_FN_STOP];
		cmd_next.halt             = halt;
		cmd_next.start_position   = fn_rise[`DIO_FN_POS_MOVE] & ~halt;
		cmd_next.start_speed      = fn_rise[`DIO_FN_SPD_MOVE] & ~halt;
		// Opposing jogs cancel so the motor never gets two directions.
		cmd_next.jog_fwd          = fn_lvl[`DIO_FN_JOG_FWD] & ~fn_lvl[`DIO_FN_JOG_BWD] & ~halt;
		cmd_next.jog_bwd          = fn_lvl[`DIO_FN_JOG_BWD] & ~fn_lvl[`DIO_FN_JOG_FWD] & ~halt;
		cmd_next.home_back        = (home_next == dio_home_back);
		cmd_next.home_fwd         = (home_next == dio_home_fwd);
		cmd_next.multi_start      = fn_rise[`DIO_FN_MULTI] & ~halt;
		cmd_next.segment_select   = fn_lvl[`DIO_FN_SEG_BASE +: 5];
		cmd_next.fwd_limit        = fn_lvl[`DIO_FN_FWD_LIM];
		cmd_next.bwd_limit        = fn_lvl[`DIO_FN_BWD_LIM];
		cmd_next.restore_defaults = fn_rise[`DIO_FN_RESTORE];
		cmd_next.ext_direction    = ext_mode & pin_sync_reg[1];
		// Position-reached only means something after a position move.
		if (cmd_next.start_position)
			pos_mode_next = 1'b1;
		else if (cmd_next.start_speed || cmd_next.jog_fwd || cmd_next.jog_bwd || cmd_next.home_back)
			pos_mode_next = 1'b0;
		// Output function sources, indexed by output code.
		out_src[`DIO_OF_ALARM]   = alarm;
		out_src[`DIO_OF_RUNNING] = motion_sts.moving;
		out_src[`DIO_OF_POS_OK]  = pos_ok;
		if (!ext_mode)
		begin
			out_src[`DIO_OF_HOME_OK]          = (home_reg == dio_home_done);
			out_src[`DIO_OF_MULTI]            = motion_sts.multi_active;
			out_src[`DIO_OF_SEG_BASE +: 3]    = motion_sts.segment_status;
		end // else
		for (int j = 0; j < 3; j++)
			gout_next[j] = out_src[out_func_reg[j*`DIO_OUT_FW +: `DIO_OUT_FW]];
	end

	// Registers of the motion and status group.
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			energise_reg   <= 1'b0;
			nvm_alarm_reg  <= 1'b0;
			comm_alarm_reg <= 1'b0;
			pos_mode_reg   <= 1'b0;
			home_reg       <= dio_home_idle;
			count_reg      <= 32'h0;
			cmd_reg        <= '0;
			gout_reg       <= 3'h0;
		end
		else
		begin
			energise_reg   <= energise_next;
			nvm_alarm_reg  <= nvm_alarm_next;
			comm_alarm_reg <= comm_alarm_next;
			pos_mode_reg   <= pos_mode_next;
			home_reg       <= home_next;
			count_reg      <= count_next;
			cmd_reg        <= cmd_next;
			gout_reg       <= gout_next;
		end
	end

	// ------------------------------------------------------------
	// APB register file
	// ------------------------------------------------------------
	dio_mode_t   mode_next;
	logic [24:0] in_func_next;
	logic [11:0] out_func_next;
	logic [31:0] prdata_reg,  prdata_next;
	logic        pready_reg,  pready_next;
	logic        pslverr_reg, pslverr_next;
	logic        hit;
	logic [31:0] rd;

	// The answer is registered, so every access waits one cycle in its access phase.
	always_comb
	begin
		mode_next     = mode_reg;
		in_func_next  = in_func_reg;
		out_func_next = out_func_reg;
		prdata_next   = prdata_reg;
		pslverr_next  = pslverr_reg;
		pready_next   = 1'b0;
		hit           = 1'b1;
		rd            = 32'h0;
		unique case (paddr)
			`DIO_OFF_CTRL:     rd = {30'h0, mode_reg};
			`DIO_OFF_IN_FUNC:  rd = {7'h0, in_func_reg};
			`DIO_OFF_OUT_FUNC: rd = {20'h0, out_func_reg};
			`DIO_OFF_STATUS:   rd = {26'h0, motion_sts.multi_active, ~energise_reg, alarm,
						motion_sts.moving, (home_reg == dio_home_done), pos_ok};
			`DIO_OFF_TERM:     rd = {21'h0, gout_reg, 1'b0, pin_sync_reg};
			`DIO_OFF_COUNT:    rd = count_reg;
			`DIO_OFF_ALARM:    rd = {28'h0, fault_in.under_voltage, fault_in.over_voltage,
						comm_alarm_reg, nvm_alarm_reg};
			default:           hit = 1'b0;
		endcase
		if (psel && penable && !pready_reg)
		begin
			pready_next  = 1'b1;
			pslverr_next = ~hit;
			prdata_next  = (hit && !pwrite) ? rd : 32'h0;
		end
		// Writes land only at the edge that completes the transfer.
		if (psel && penable && pready_reg && pwrite && hit)
		begin
			unique case (paddr)
				`DIO_OFF_CTRL:     mode_next     = dio_mode_t'(pwdata[1:0]);
				`DIO_OFF_IN_FUNC:  in_func_next  = pwdata[24:0];
				`DIO_OFF_OUT_FUNC: out_func_next = pwdata[11:0];
				default:           mode_next     = mode_reg;
			endcase
		end
		// Restore beats a same-cycle write so defaults are certain afterwards.
		if (fn_rise[`DIO_FN_RESTORE])
		begin
			mode_next     = dio_mode_t'(`DIO_MODE_RST);
			in_func_next  = `DIO_IN_FUNC_RST;
			out_func_next = `DIO_OUT_FUNC_RST;
		end
	end

	// Registers of the bus group.
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			mode_reg     <= dio_mode_t'(`DIO_MODE_RST);
			in_func_reg  <= `DIO_IN_FUNC_RST;
			out_func_reg <= `DIO_OUT_FUNC_RST;
			prdata_reg   <= 32'h0;
			pready_reg   <= 1'b0;
			pslverr_reg  <= 1'b0;
		end
		else
		begin
			mode_reg     <= mode_next;
			in_func_reg  <= in_func_next;
			out_func_reg <= out_func_next;
			prdata_reg   <= prdata_next;
			pready_reg   <= pready_next;
			pslverr_reg  <= pslverr_next;
		end
	end

	// Outputs.
	assign prdata         = prdata_reg;
	assign pready         = pready_reg;
	assign pslverr        = pslverr_reg;
	assign general_output = gout_reg;
	assign motion_cmd     = cmd_reg;
endmodule : dio_terminals

// ---- sim/dio_terminals_asserts.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port-level checks for the terminal function block.
// ----------------------------------------------------------------
module dio_terminals_asserts
	import dio_pkg::*;
(
	// Clock, reset and APB.
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Terminals and motion core.
	input wire logic        step_pulse_in,
	input wire logic        step_direction_in,
	input wire logic [4:0]  general_input,
	input wire logic [2:0]  general_output,
	input wire dio_cmd_t    motion_cmd,
	input wire dio_sts_t    motion_sts,
	input wire dio_fault_t  fault_in
);
	logic [1:0] mode_reg;
	logic [1:0] mode_next;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	// Shadow of the control mode, since one rule holds only in bus mode and one only outside it.
	always_comb
	begin
		mode_next = mode_reg;
		if (psel && penable && pready && pwrite && paddr == 12'h000 && !pslverr)
			mode_next = pwdata[1:0];
		if (motion_cmd.restore_defaults)
			mode_next = 2'h0;
	end

	// The shadow register itself.
	always_ff @(posedge ref_clk)
		mode_reg <= rst ? 2'h0 : mode_next;

	chk_enable_locks: assert property ((!general_input[0] && !general_input[1]) ##1
		(general_input[0] && !general_input[1]) [*3] |=> motion_cmd.energise) else $error("enable did not energise");
	chk_release_wins: assert property (general_input[1] [*3] |=> !motion_cmd.energise)
		else $error("energise high under release");
	chk_estop_halt: assert property ((general_input[4] && mode_reg == 2'h0) [*3] |=> motion_cmd.halt)
		else $error("estop did not halt");
	chk_estop_blocks: assert property (motion_cmd.halt && $past(motion_cmd.halt) |-> !(motion_cmd.jog_fwd
		|| motion_cmd.jog_bwd || motion_cmd.start_position || motion_cmd.start_speed || motion_cmd.multi_start))
		else $error("motion started under estop");
	chk_jog_single: assert property (!(motion_cmd.jog_fwd && motion_cmd.jog_bwd))
		else $error("both jog directions");
	chk_alarm_out: assert property (fault_in.over_voltage [*2] |-> ##[1:3] general_output[0])
		else $error("alarm output missing");
	chk_ext_ignores: assert property ((mode_reg != 2'h0) [*3] |-> !motion_cmd.jog_fwd
		&& !motion_cmd.jog_bwd && !motion_cmd.halt) else $error("function honoured in pulse mode");
	chk_apb_ready: assert property (psel && $rose(penable) |=> pready) else $error("late ready");
	chk_apb_unmapped: assert property (pready && paddr > 12'h018 |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
endmodule : dio_terminals_asserts

bind dio_terminals dio_terminals_asserts u_chk (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.step_pulse_in(step_pulse_in), .step_direction_in(step_direction_in), .general_input(general_input),
	.general_output(general_output), .motion_cmd(motion_cmd), .motion_sts(motion_sts), .fault_in(fault_in));

// ---- sim/dio_motion_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Behavioural motion core answering the block's commands.
// ----------------------------------------------------------------
module dio_motion_model
	import dio_pkg::*;
#(
	parameter int MOVE_LEN = 5
)
(
	// Clock and reset.
	input  wire logic     ref_clk,
	input  wire logic     rst,
	// Command in, status out.
	input  wire dio_cmd_t cmd,
	output dio_sts_t      sts
);
	int   cnt_reg;
	int   cnt_next;
	logic multi_reg;
	logic multi_next;

	// A move runs MOVE_LEN cycles; either stop kind cuts it short at once.
	always_comb
	begin
		cnt_next = (cnt_reg > 0) ? cnt_reg - 1 : 0;
		if (cmd.start_position || cmd.start_speed)
			cnt_next = MOVE_LEN;
		if (cmd.halt || cmd.decel_stop)
			cnt_next = 0;
		multi_next = multi_reg | cmd.multi_start;
	end

	// State registers.
	always_ff @(posedge ref_clk)
	begin
		cnt_reg   <= rst ? 0 : cnt_next;
		multi_reg <= rst ? 1'b0 : multi_next;
	end

	// Held jog counts as motion; segment code is arbitrary but nonzero while a multi run is active, zero otherwise.
	assign sts = '{moving: (cnt_reg > 0) || cmd.jog_fwd || cmd.jog_bwd, at_target: cnt_reg == 0,
		multi_active: multi_reg, segment_status: multi_reg ? 3'h5 : 3'h0};
endmodule : dio_motion_model

// ---- sim/tb.sv ----
`timescale 1ns/1ps
`include "dio_cfg.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
	$display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
// ----------------------------------------------------------------
// Self-checking bench for the terminal function block.
// ----------------------------------------------------------------
module tb
	import dio_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd_val;
	logic [31:0] base;
	logic [31:0] seed = 32'h3e12ae50;
	logic        pready;
	logic        pslverr;
	logic        rd_err;
	logic        pulse = 1'b0;
	logic        dir = 1'b0;
	logic [4:0]  gi = 5'h00;
	logic [2:0]  go;
	logic [2:0]  go_seen;
	dio_cmd_t    cmd;
	dio_cmd_t    seen;
	dio_sts_t    sts;
	dio_fault_t  flt = '0;
	int          n_fail = 0;
	int          cmp_count = 0;
	int          n;
	logic [4:0]  fn_code [10] = '{`DIO_FN_STOP, `DIO_FN_POS_MOVE, `DIO_FN_SPD_MOVE, `DIO_FN_JOG_FWD,
		`DIO_FN_JOG_BWD, `DIO_FN_MULTI, `DIO_FN_SEG_BASE, `DIO_FN_FWD_LIM, `DIO_FN_BWD_LIM, `DIO_FN_RESTORE};
	int          fn_bit [10] = '{17, 15, 14, 13, 12, 9, 4, 3, 2, 1};

	always #5 ref_clk = ~ref_clk;

	dio_terminals u_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.step_pulse_in(pulse), .step_direction_in(dir), .general_input(gi), .general_output(go),
		.motion_cmd(cmd), .motion_sts(sts), .fault_in(flt));
	dio_motion_model u_core (.ref_clk(ref_clk), .rst(rst), .cmd(cmd), .sts(sts));

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	// Input map with X2 and X3 chosen, the other terminals at their defaults.
	function automatic logic [31:0] in_map(input logic [4:0] t2, input logic [4:0] t3);
		return {7'h00, 5'h0b, t3, t2, 10'h0e6};
	endfunction : in_map

	// Step count change: down with direction high or on reverse pulses, nothing in bus or direction mode.
	function automatic logic [31:0] exp_delta(input int m, input logic d, input int k);
		return (m >= 2 && d) ? 32'(-k) : (m >= 2) ? 32'(k) : 32'h0;
	endfunction : exp_delta

	// One APB transfer, entered and left right after a rising edge.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge ref_clk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		if (k >= 20)
			n_fail++;
		rd_val = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb

	// Holds one input pin high for eight cycles and gathers what the block shows.
	task pin(input int b);
		seen = '0;
		go_seen = '0;
		gi[b] <= 1'b1;
		for (int i = 0; i < 16; i++)
		begin
			@(posedge ref_clk);
			seen = dio_cmd_t'(seen | cmd);
			go_seen = go_seen | go;
			if (i == 7)
				gi[b] <= 1'b0;
		end
	endtask : pin

	task final_report;
		$display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report

	// Watchdog: the whole sequence needs about a thousand cycles, so this 20000-cycle span leaves ample margin.
	initial
	begin
		#200000;
		n_fail++;
		final_report();
	end

	// Main sequence.
	initial
	begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		apb(1'b0, 12'h01c, 32'h0);
		`CHK({rd_err, rd_val}, 33'h100000000)
		pin(0);
		apb(1'b0, `DIO_OFF_STATUS, 32'h0);
		`CHK(rd_val[4], 1'b0)
		gi[1] <= 1'b1;
		repeat (5) @(posedge ref_clk);
		`CHK(cmd.energise, 1'b0)
		gi[1] <= 1'b0;
		flt.nvm_error <= 1'b1;
		flt.comm_error <= 1'b1;
		@(posedge ref_clk);
		flt.nvm_error <= 1'b0;
		flt.comm_error <= 1'b0;
		repeat (5) @(posedge ref_clk);
		`CHK(go[0], 1'b1)
		apb(1'b0, `DIO_OFF_ALARM, 32'h0);
		`CHK(rd_val[3:0], 4'h3)
		pin(2);
		`CHK(go[0], 1'b0)
		flt.over_voltage <= 1'b1;
		repeat (5) @(posedge ref_clk);
		apb(1'b0, `DIO_OFF_STATUS, 32'h0);
		`CHK(rd_val[3], 1'b1)
		flt.over_voltage <= 1'b0;
		repeat (5) @(posedge ref_clk);
		`CHK(go[0], 1'b0)
		pin(4);
		`CHK(seen.halt, 1'b1)
		for (int i = 0; i < 10; i++)
		begin
			apb(1'b1, `DIO_OFF_IN_FUNC, in_map(5'h08, fn_code[i]));
			pin(3);
			`CHK(seen[fn_bit[i]], 1'b1)
			if (i == 1)
				`CHK({go_seen[1], go[2:1]}, 3'b110)
		end
		apb(1'b0, `DIO_OFF_IN_FUNC, 32'h0);
		`CHK(rd_val, in_map(5'h08, 5'h03))
		apb(1'b1, `DIO_OFF_OUT_FUNC, 32'h621);
		apb(1'b1, `DIO_OFF_IN_FUNC, in_map(`DIO_FN_HOME, `DIO_FN_ORIGIN));
		pin(2);
		`CHK(seen.home_back, 1'b1)
		apb(1'b1, `DIO_OFF_IN_FUNC, in_map(`DIO_FN_HOME, `DIO_FN_BWD_LIM));
		pin(3);
		`CHK(seen.home_fwd, 1'b1)
		apb(1'b1, `DIO_OFF_IN_FUNC, in_map(`DIO_FN_HOME, `DIO_FN_ORIGIN));
		pin(3);
		apb(1'b0, `DIO_OFF_STATUS, 32'h0);
		`CHK({rd_val[1], go[2:1]}, 3'b111)
		apb(1'b1, `DIO_OFF_OUT_FUNC, 32'h351);
		repeat (2) @(posedge ref_clk);
		`CHK(go[2:1], 2'b01)
		apb(1'b1, `DIO_OFF_OUT_FUNC, 32'h871);
		repeat (2) @(posedge ref_clk);
		`CHK(go[2:1], 2'b10)
		// Every mode twice: direction low first, then high.
		for (int m = 0; m < 8; m++)
		begin
			seed = lfsr(seed);
			n = 1 + seed[3:0];
			dir <= m[2];
			repeat (4) @(posedge ref_clk);
			apb(1'b1, `DIO_OFF_CTRL, 32'(m % 4));
			apb(1'b0, `DIO_OFF_COUNT, 32'h0);
			base = rd_val;
			repeat (2 * n)
			begin
				repeat (2) @(posedge ref_clk);
				// Dual-pulse mode with direction high sends reverse pulses on the direction pin.
				if (m == 7)
					dir <= ~dir;
				else
					pulse <= ~pulse;
			end
			repeat (4) @(posedge ref_clk);
			apb(1'b0, `DIO_OFF_COUNT, 32'h0);
			`CHK(rd_val - base, exp_delta(m % 4, dir, n))
			if (m % 4 == 1)
				`CHK(cmd.ext_direction, dir)
			if (m == 2)
			begin
				apb(1'b1, `DIO_OFF_IN_FUNC, in_map(5'h08, `DIO_FN_JOG_FWD));
				pin(3);
				`CHK(seen.jog_fwd, 1'b0)
			end
		end
		final_report();
	end
endmodule : tb
